// ==== shared/twebc_pkg.sv ====
// Constants and types shared by the two-wire EEPROM bus client.
// Function
// R01: Bits are sampled on SCL rise and SDA is only changed after SCL fall.
// R02: Every byte moves most significant bit first, one bit per SCL cycle.
// R03: Each byte is followed by an acknowledge slot, nine clocks per byte.
// R04: The host clocks each nine-cycle group without gaps.
// R05: The driving party changes SDA only while SCL is low.
// R06: An SDA change while SCL is high is a start or stop, never data.
// R07: The number of bytes between start and stop is not limited.
// R08: The bus is idle only with SCL and SDA both high.
// R09: The host starts every transfer and makes every SCL cycle.
// R10: While in reset the client ignores the bus and then enters standby.
// R11: The host waits the power-up command delay before its first command.
// R12: Pulses on SCL or SDA shorter than 50 ns are rejected.
// R13: A start is SDA falling with SCL high and begins every command.
// R14: A stop is SDA rising with SCL high and ends the transfer.
// R15: The sender releases SDA after bit eight; the receiver acks low.
// R16: The host allows for the self-timed write before a new command; the bench skips write_wait after t_full before the next start.
// R17: The client leaves SDA released whenever it is not sending a bit.
package twebc_pkg;

	localparam int          LINK_CLK_NS   = 48;
	localparam int          GLITCH_NS     = 50;
	localparam int          GLITCH_CYC    =
		(GLITCH_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
	localparam logic [1:0]  GLITCH_LAST   = 2'(GLITCH_CYC - 1);
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [3:0]  LAST_TX_BIT   = 4'h7;
	localparam int          RW_BIT        = 0;
	localparam int          FIFO_DEPTH    = 4;
	localparam int          PIN_SCL       = 1;
	localparam int          PIN_SDA       = 0;
	localparam logic [1:0]  PINS_IDLE     = 2'h3;
	localparam logic [7:0]  BYTE_RELEASED = 8'hFF;

	typedef logic [7:0] twebc_byte_t;

	typedef struct packed {
		logic        first;
		twebc_byte_t data;
	} twebc_rx_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RECV = 5'h02,
		ST_RACK = 5'h04,
		ST_SEND = 5'h08,
		ST_SACK = 5'h10
	} twebc_state_t;

endpackage

// ==== design/twebc_top.sv ====
// Two-wire EEPROM bus client: pin filter, bit engine and byte FIFOs.

// Dual-clock FIFO with gray pointers and a registered read port.
module twebc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	// Write side
	input  wire logic         i_wclk,
	input  wire logic         i_wnrst,
	input  wire logic         i_wce,
	input  wire logic         i_wvalid,
	input  wire logic [W-1:0] i_wdata,
	output logic              o_wready,
	// Read side
	input  wire logic         i_rclk,
	input  wire logic         i_rnrst,
	input  wire logic         i_rce,
	input  wire logic         i_rready,
	output logic              o_rvalid,
	output logic [W-1:0]      o_rdata
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [AW:0]  wbin_r;
	logic [AW:0]  wgray_r;
	logic [AW:0]  rq1_r;
	logic [AW:0]  rq2_r;
	logic [AW:0]  rbin_r;
	logic [AW:0]  rgray_r;
	logic [AW:0]  wq1_r;
	logic [AW:0]  wq2_r;
	logic [AW:0]  wbin_nxt;
	logic [AW:0]  wgray_nxt;
	logic [AW:0]  rbin_nxt;
	logic [AW:0]  rgray_nxt;
	logic         wpush;
	logic         rpop;
	logic         empty;

	assign wpush     = i_wce && i_wvalid && o_wready;
	assign wbin_nxt  = wbin_r + (AW + 1)'(wpush);
	assign wgray_nxt = wbin_nxt ^ (wbin_nxt >> 1);
	assign empty     = rgray_r == wq2_r;
	assign rpop      = i_rce && !empty && (!o_rvalid || i_rready);
	assign rbin_nxt  = rbin_r + (AW + 1)'(rpop);
	assign rgray_nxt = rbin_nxt ^ (rbin_nxt >> 1);

	// Ready is computed from the next pointer so it never lags a push.
	always_ff @(posedge i_wclk or negedge i_wnrst) begin
		if (!i_wnrst) begin
			wbin_r   <= '0;
			wgray_r  <= '0;
			o_wready <= 1'b0;
		end else if (i_wce) begin
			wbin_r   <= wbin_nxt;
			wgray_r  <= wgray_nxt;
			o_wready <= wgray_nxt !=
				{~rq2_r[AW:AW-1], rq2_r[AW-2:0]};
		end
	end

	always_ff @(posedge i_wclk) begin
		if (wpush) begin
			mem_r[wbin_r[AW-1:0]] <= i_wdata;
		end
	end

	always_ff @(posedge i_wclk or negedge i_wnrst) begin
		if (!i_wnrst) begin
			rq1_r <= '0;
			rq2_r <= '0;
		end else begin
			rq1_r <= rgray_r;
			rq2_r <= rq1_r;
		end
	end

	always_ff @(posedge i_rclk or negedge i_rnrst) begin
		if (!i_rnrst) begin
			wq1_r <= '0;
			wq2_r <= '0;
		end else begin
			wq1_r <= wgray_r;
			wq2_r <= wq1_r;
		end
	end

	always_ff @(posedge i_rclk or negedge i_rnrst) begin
		if (!i_rnrst) begin
			rbin_r   <= '0;
			rgray_r  <= '0;
			o_rvalid <= 1'b0;
			o_rdata  <= '0;
		end else if (i_rce) begin
			rbin_r  <= rbin_nxt;
			rgray_r <= rgray_nxt;
			if (rpop) begin
				o_rvalid <= 1'b1;
				o_rdata  <= mem_r[rbin_r[AW-1:0]];
			end else if (i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end
endmodule

module twebc_top (
	// Clocks, reset and enable
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic               i_ce,
	input  wire logic               i_link_clk,
	// Bus pins
	input  wire logic               i_scl,
	input  wire logic               i_sda,
	output logic                    o_sda_o,
	output logic                    o_sda_oe,
	// Received bytes
	output twebc_pkg::twebc_rx_t    o_rx_data,
	output logic                    o_rx_valid,
	input  wire logic               i_rx_ready,
	// Bytes to send
	input  wire twebc_pkg::twebc_byte_t i_tx_data,
	input  wire logic               i_tx_valid,
	output logic                    o_tx_ready
);
	import twebc_pkg::*;

	logic         nrst_l1_r;
	logic         nrst_l;
	logic         ce_l1_r;
	logic         ce_l;
	logic [1:0]   pin_s1_r;
	logic [1:0]   pin_s2_r;
	logic [1:0]   pin_s3_r;
	logic [1:0]   filt_r;
	logic [1:0]   prev_r;
	logic [1:0]   gcnt_r [2];
	logic         scl_rise;
	logic         scl_fall;
	logic         start_det;
	logic         stop_det;
	twebc_state_t state_r;
	logic [3:0]   bitcnt_r;
	twebc_byte_t  shreg_r;
	logic         sda_oe_r;
	logic         sda_o_r;
	logic         first_r;
	logic         rd_r;
	logic         ackd_r;
	logic         push_r;
	logic         pop_r;
	twebc_rx_t    rxw_r;
	logic         rx_wready;
	logic         tx_valid;
	twebc_byte_t  tx_data;

	assign o_sda_oe = sda_oe_r;
	assign o_sda_o  = sda_o_r;

	// Link reset asserts at once and releases on the link clock.
	always_ff @(posedge i_link_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			nrst_l1_r <= 1'b0;
			nrst_l    <= 1'b0;
		end else begin
			nrst_l1_r <= 1'b1;
			nrst_l    <= nrst_l1_r;
		end
	end

	always_ff @(posedge i_link_clk or negedge nrst_l) begin
		if (!nrst_l) begin
			ce_l1_r <= 1'b0;
			ce_l    <= 1'b0;
			sda_o_r <= 1'b0;
		end else begin
			ce_l1_r <= i_ce;
			ce_l    <= ce_l1_r;
			sda_o_r <= 1'b0;
		end
	end

	always_ff @(posedge i_link_clk or negedge nrst_l) begin
		if (!nrst_l) begin
			pin_s1_r <= PINS_IDLE; // [R08]
			pin_s2_r <= PINS_IDLE;
			pin_s3_r <= PINS_IDLE;
		end else begin
			pin_s1_r <= {i_scl, i_sda};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	// A new level is taken only after it stood long enough.
	always_ff @(posedge i_link_clk or negedge nrst_l) begin
		if (!nrst_l) begin
			filt_r <= PINS_IDLE;
			prev_r <= PINS_IDLE;
			gcnt_r <= '{default: '0};
		end else if (ce_l) begin
			prev_r <= filt_r;
			for (int i = 0; i < 2; i++) begin
				if (pin_s2_r[i] != pin_s3_r[i] ||
					pin_s3_r[i] == filt_r[i]) begin
					gcnt_r[i] <= '0; // [R12]
				end else if (gcnt_r[i] == GLITCH_LAST) begin
					filt_r[i] <= pin_s3_r[i];
					gcnt_r[i] <= '0;
				end else begin
					gcnt_r[i] <= gcnt_r[i] + 2'h1;
				end
			end
		end
	end

	assign scl_rise  = filt_r[PIN_SCL] && !prev_r[PIN_SCL];
	assign scl_fall  = !filt_r[PIN_SCL] && prev_r[PIN_SCL];
	// SDA moving under a steady high SCL is framing. [R06]
	assign start_det = filt_r[PIN_SCL] && prev_r[PIN_SCL] &&
		prev_r[PIN_SDA] && !filt_r[PIN_SDA]; // [R13]
	assign stop_det  = filt_r[PIN_SCL] && prev_r[PIN_SCL] &&
		!prev_r[PIN_SDA] && filt_r[PIN_SDA]; // [R14]

	// Bit engine; reset holds it in standby with SDA released. [R10]
	always_ff @(posedge i_link_clk or negedge nrst_l) begin
		if (!nrst_l) begin
			state_r  <= ST_IDLE;
			bitcnt_r <= '0;
			shreg_r  <= '0;
			sda_oe_r <= 1'b0;
			first_r  <= 1'b0;
			rd_r     <= 1'b0;
			ackd_r   <= 1'b0;
			push_r   <= 1'b0;
			pop_r    <= 1'b0;
			rxw_r    <= '0;
		end else if (ce_l) begin
			push_r <= 1'b0;
			pop_r  <= 1'b0;
			if (start_det) begin
				state_r  <= ST_RECV; // [R13]
				bitcnt_r <= '0;
				first_r  <= 1'b1;
				rd_r     <= 1'b0;
				sda_oe_r <= 1'b0;
			end else if (stop_det) begin
				state_r  <= ST_IDLE; // [R14]
				sda_oe_r <= 1'b0;
			end else begin
				unique case (state_r)
				ST_IDLE: begin
					sda_oe_r <= 1'b0; // [R17]
				end
				ST_RECV: begin
					if (scl_rise) begin
						shreg_r  <= {shreg_r[6:0],
							filt_r[PIN_SDA]}; // [R01] [R02]
						bitcnt_r <= bitcnt_r + 4'h1;
					end else if (scl_fall &&
						bitcnt_r == BITS_PER_BYTE) begin
						// A full FIFO refuses the byte with a NACK.
						ackd_r   <= rx_wready;
						sda_oe_r <= rx_wready; // [R15] [R03]
						push_r   <= rx_wready;
						rxw_r    <= '{first: first_r, data: shreg_r};
						if (first_r) begin
							rd_r <= shreg_r[RW_BIT];
						end
						state_r <= ST_RACK;
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						sda_oe_r <= 1'b0; // [R17]
						first_r  <= 1'b0;
						bitcnt_r <= '0;
						if (!ackd_r) begin
							state_r <= ST_IDLE;
						end else if (rd_r) begin
							state_r  <= ST_SEND;
							shreg_r  <= tx_valid ? tx_data
								: BYTE_RELEASED;
							sda_oe_r <= tx_valid && !tx_data[7];
							pop_r    <= tx_valid;
						end else begin
							state_r <= ST_RECV; // [R07]
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						bitcnt_r <= bitcnt_r + 4'h1;
						if (bitcnt_r == LAST_TX_BIT) begin
							sda_oe_r <= 1'b0; // [R15]
							state_r  <= ST_SACK;
						end else begin
							shreg_r  <= {shreg_r[6:0], 1'b0};
							sda_oe_r <= !shreg_r[6]; // [R02] [R05]
						end
					end
				end
				ST_SACK: begin
					if (scl_rise) begin
						ackd_r <= !filt_r[PIN_SDA]; // [R03]
					end else if (scl_fall) begin
						bitcnt_r <= '0;
						if (ackd_r) begin
							state_r  <= ST_SEND; // [R07]
							shreg_r  <= tx_valid ? tx_data
								: BYTE_RELEASED;
							sda_oe_r <= tx_valid && !tx_data[7];
							pop_r    <= tx_valid;
						end else begin
							state_r <= ST_IDLE; // [R17]
						end
					end
				end
				default: begin
					state_r  <= ST_IDLE;
					sda_oe_r <= 1'b0;
				end
				endcase
			end
		end
	end

	twebc_fifo #(
		.W     ($bits(twebc_rx_t)),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.i_wclk   (i_link_clk),
		.i_wnrst  (nrst_l),
		.i_wce    (ce_l),
		.i_wvalid (push_r),
		.i_wdata  (rxw_r),
		.o_wready (rx_wready),
		.i_rclk   (i_clk),
		.i_rnrst  (i_nrst),
		.i_rce    (i_ce),
		.i_rready (i_rx_ready),
		.o_rvalid (o_rx_valid),
		.o_rdata  (o_rx_data)
	);

	twebc_fifo #(
		.W     ($bits(twebc_byte_t)),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.i_wclk   (i_clk),
		.i_wnrst  (i_nrst),
		.i_wce    (i_ce),
		.i_wvalid (i_tx_valid),
		.i_wdata  (i_tx_data),
		.o_wready (o_tx_ready),
		.i_rclk   (i_link_clk),
		.i_rnrst  (nrst_l),
		.i_rce    (ce_l),
		.i_rready (pop_r),
		.o_rvalid (tx_valid),
		.o_rdata  (tx_data)
	);

	sda_timing_a: assert property ( // [R01] [R05]
		@(posedge i_link_clk) disable iff (!nrst_l || !ce_l)
		$changed(sda_oe_r) |->
			$past(scl_fall || start_det || stop_det))
		else $error("SDA drive changed without an SCL fall");

	glitch_hold_a: assert property ( // [R12]
		@(posedge i_link_clk) disable iff (!nrst_l || !ce_l)
		$changed(filt_r[PIN_SCL]) |->
			$past(pin_s3_r[PIN_SCL], 1) == filt_r[PIN_SCL] &&
			$past(pin_s3_r[PIN_SCL], 2) == filt_r[PIN_SCL])
		else $error("SCL level taken before it stood two samples");

	ack_slot_a: assert property ( // [R03] [R15]
		@(posedge i_link_clk) disable iff (!nrst_l || !ce_l)
		state_r == ST_RECV && scl_fall && !start_det && !stop_det &&
		bitcnt_r == BITS_PER_BYTE && rx_wready
		|=> state_r == ST_RACK && sda_oe_r && push_r)
		else $error("Received byte not acknowledged");

	msb_first_a: assert property ( // [R02]
		@(posedge i_link_clk) disable iff (!nrst_l || !ce_l)
		state_r == ST_SEND |-> sda_oe_r == !shreg_r[7])
		else $error("Sent bit is not the byte's top bit");

	start_frame_a: assert property ( // [R13] [R06]
		@(posedge i_link_clk) disable iff (!nrst_l || !ce_l)
		start_det |=> state_r == ST_RECV && bitcnt_r == 4'h0 &&
			!sda_oe_r)
		else $error("Start did not open a new byte");

	stop_frame_a: assert property ( // [R14]
		@(posedge i_link_clk) disable iff (!nrst_l || !ce_l)
		stop_det && !start_det |=> state_r == ST_IDLE && !sda_oe_r)
		else $error("Stop did not return to standby");

	idle_release_a: assert property ( // [R17]
		@(posedge i_link_clk) disable iff (!nrst_l)
		state_r == ST_IDLE |-> !sda_oe_r && !o_sda_o)
		else $error("SDA driven in standby");

	reset_quiet_a: assert property ( // [R10]
		@(posedge i_link_clk)
		$rose(nrst_l) |-> state_r == ST_IDLE && !sda_oe_r)
		else $error("Client active while leaving reset");

	no_limit_a: assert property ( // [R07]
		@(posedge i_link_clk) disable iff (!nrst_l || !ce_l)
		state_r == ST_RACK && ackd_r && !rd_r && scl_fall &&
		!start_det && !stop_det |=> state_r == ST_RECV)
		else $error("Write stream stopped after a byte");

	write_byte_c: cover property (
		@(posedge i_link_clk) disable iff (!nrst_l)
		push_r && !rxw_r.first);

	read_byte_c: cover property (
		@(posedge i_link_clk) disable iff (!nrst_l)
		state_r == ST_SEND ##[1:1000] state_r == ST_SACK);

	host_nack_c: cover property (
		@(posedge i_link_clk) disable iff (!nrst_l)
		state_r == ST_SACK && scl_fall && !ackd_r);

	stop_seen_c: cover property (
		@(posedge i_link_clk) disable iff (!nrst_l)
		stop_det);
endmodule

// ==== verif/twebc_host_model.sv ====
// Bus host model: drives SCL and an open-drain pull on SDA.
module twebc_host_model #(
	parameter int HALF_NS = 800,
	parameter int PUP_NS  = 100000,
	parameter int WR_NS   = 2000
) (
	// Pins
	output logic      o_scl,
	output logic      o_sda_oe,
	input  wire logic i_sda
);
	timeunit 1ns;
	timeprecision 1ns;
	import twebc_pkg::*;

	initial begin
		o_scl    = 1'b1;
		o_sda_oe = 1'b0;
	end

	task automatic pup_wait;
		#(PUP_NS);
	endtask

	// No memory sits behind the client, so a short pause stands in
	// for the self-timed write time.
	task automatic write_wait;
		#(WR_NS);
	endtask

	task automatic start;
		o_sda_oe = 1'b0;
		#(HALF_NS);
		o_scl = 1'b1;
		#(HALF_NS);
		o_sda_oe = 1'b1;
		#(HALF_NS);
		o_scl = 1'b0;
	endtask

	task automatic stop;
		o_sda_oe = 1'b1;
		#(HALF_NS);
		o_scl = 1'b1;
		#(HALF_NS);
		o_sda_oe = 1'b0;
		#(HALF_NS);
	endtask

	// A glitch puts a 30 ns SCL spike into the low phase.
	task automatic bit_cycle(input logic b, input logic g, output logic s);
		o_sda_oe = ~b;
		#(HALF_NS / 2);
		if (g) begin
			o_scl = 1'b1;
			#30;
			o_scl = 1'b0;
		end
		#(HALF_NS / 2);
		o_scl = 1'b1;
		#(HALF_NS / 2);
		s = i_sda;
		#(HALF_NS / 2);
		o_scl = 1'b0;
	endtask

	task automatic wr_byte(input twebc_byte_t d, input logic g,
			output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(d[i], g && (i == 3), s);
		end
		bit_cycle(1'b1, 1'b0, ack);
	endtask

	task automatic rd_byte(input logic nack, output twebc_byte_t d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, 1'b0, d[i]);
		end
		bit_cycle(nack, 1'b0, s);
	endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the two-wire EEPROM bus client.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import twebc_pkg::*;

	logic        i_clk      = 1'b0;
	logic        i_nrst     = 1'b0;
	logic        i_link_clk = 1'b0;
	logic        rx_ready   = 1'b0;
	logic        tx_valid   = 1'b0;
	twebc_byte_t tx_data    = 8'h00;
	logic        scl;
	logic        host_oe;
	logic        dut_o;
	logic        dut_oe;
	logic        tx_ready;
	logic        rx_valid;
	twebc_rx_t   rx_word;
	wire logic   sda_w;
	int          bad_count  = 0;
	int          checked    = 0;
	int          cyc        = 0;

	// Pull-up: the line is low only while somebody pulls it.
	assign sda_w = !(host_oe || (dut_oe && !dut_o));

	always #5 i_clk = ~i_clk;
	initial begin
		#7;
		forever #24 i_link_clk = ~i_link_clk;
	end

	twebc_top dut_u (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1),
		.i_link_clk(i_link_clk), .i_scl(scl), .i_sda(sda_w),
		.o_sda_o(dut_o), .o_sda_oe(dut_oe), .o_rx_data(rx_word),
		.o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
		.i_tx_data(tx_data), .i_tx_valid(tx_valid),
		.o_tx_ready(tx_ready)
	);

	twebc_host_model host_u (
		.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda_w)
	);

	task automatic chk(input logic ok, input string msg);
		checked++;
		if (!ok) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	task automatic wrap_up;
		$display("counts: checked=%0d bad=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			bad_count++;
			$display("MISMATCH %0t run too long", $time);
			wrap_up();
		end
	end

	task automatic pop(output twebc_rx_t w, output logic got);
		got = 1'b0;
		w = '0;
		for (int k = 0; k < 40 && !got; k++) begin
			@(negedge i_clk);
			if (rx_valid === 1'b1) begin
				w = rx_word;
				got = 1'b1;
			end
		end
		if (got) begin
			rx_ready = 1'b1;
			@(negedge i_clk);
			rx_ready = 1'b0;
		end
	endtask

	task automatic expect_rx(input logic f, input twebc_byte_t d);
		twebc_rx_t w;
		logic      got;
		pop(w, got);
		chk(got && (w === {f, d}), "received word wrong");
	endtask

	task automatic push(input twebc_byte_t d);
		for (int k = 0; k < 20 && tx_ready !== 1'b1; k++) begin
			@(negedge i_clk);
		end
		chk(tx_ready === 1'b1, "tx fifo never ready");
		tx_data = d;
		tx_valid = 1'b1;
		@(negedge i_clk);
		tx_valid = 1'b0;
		@(negedge i_clk);
	endtask

	task automatic t_reset;
		logic ack;
		@(negedge i_clk);
		i_nrst = 1'b0;
		host_u.start();
		host_u.wr_byte(8'hA0, 1'b0, ack);
		chk(ack === 1'b1, "acked in reset");
		chk(dut_oe === 1'b0 && tx_ready === 1'b0, "reset outputs");
		host_u.stop();
		chk(rx_valid === 1'b0, "word taken in reset");
		@(negedge i_clk);
		i_nrst = 1'b1;
		host_u.pup_wait();
		chk(tx_ready === 1'b1 && rx_valid === 1'b0, "after reset");
		$display("test reset done");
	endtask

	task automatic t_write(input logic g);
		logic ack;
		host_u.start();
		host_u.wr_byte(8'hA0, 1'b0, ack);
		chk(ack === 1'b0, "address not acked");
		host_u.wr_byte(8'h5A, g, ack);
		chk(ack === 1'b0, "data not acked");
		host_u.start();
		host_u.wr_byte(8'h42, 1'b0, ack);
		chk(ack === 1'b0, "restart not acked");
		host_u.wr_byte(8'h81, g, ack);
		chk(ack === 1'b0, "data not acked");
		host_u.stop();
		host_u.write_wait();
		expect_rx(1'b1, 8'hA0);
		expect_rx(1'b0, 8'h5A);
		expect_rx(1'b1, 8'h42);
		expect_rx(1'b0, 8'h81);
		$display("test write done, glitch=%0b", g);
	endtask

	task automatic t_full;
		twebc_byte_t b[6];
		twebc_rx_t   w;
		logic        ack;
		logic        got;
		int          n;
		b = '{8'hA0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		n = 0;
		host_u.start();
		for (int k = 0; k < 6; k++) begin
			host_u.wr_byte(b[k], 1'b0, ack);
			if (ack === 1'b0) begin
				n++;
			end
			if (k < 4) begin
				chk(ack === 1'b0, "byte with room not acked");
			end
		end
		chk(ack === 1'b1, "full fifo still acked");
		host_u.stop();
		repeat (50) @(negedge i_clk);
		for (int k = 0; k < n; k++) begin
			expect_rx(k == 0, b[k]);
		end
		pop(w, got);
		chk(got === 1'b0, "more words than acks");
		$display("test full done, acked=%0d", n);
	endtask

	task automatic t_read;
		twebc_byte_t b[5];
		twebc_byte_t d;
		logic        ack;
		// The fifth read finds the send FIFO empty: the line stays released.
		b = '{8'hC3, 8'h96, 8'h0F, 8'hE1, BYTE_RELEASED};
		for (int k = 0; k < 4; k++) begin
			push(b[k]);
		end
		@(negedge i_clk);
		chk(tx_ready === 1'b0, "tx fifo not full");
		host_u.start();
		host_u.wr_byte(8'hA1, 1'b0, ack);
		chk(ack === 1'b0, "read address not acked");
		for (int k = 0; k < 5; k++) begin
			host_u.rd_byte(k == 4, d);
			chk(d === b[k], "read byte wrong");
		end
		#400;
		chk(sda_w === 1'b1, "sda held after nack");
		host_u.stop();
		chk(sda_w === 1'b1 && scl === 1'b1, "bus not idle");
		expect_rx(1'b1, 8'hA1);
		chk(tx_ready === 1'b1, "tx fifo not drained");
		$display("test read done");
	endtask

	initial begin
		repeat (3) @(negedge i_clk);
		i_nrst = 1'b1;
		host_u.pup_wait();
		t_write(1'b0);
		t_write(1'b1);
		t_full();
		t_read();
		t_reset();
		t_write(1'b0);
		wrap_up();
	end
endmodule
